// >>> dv/sciex_props.sv
/* Port assertions for the execute slice.
   Bound into every sciex_exec instance below. */
`timescale 1ns/1ps
module sciex_props (
   input wire logic                          i_clk_sys,
   input wire logic                          i_srst,
   input wire sciex_pkg::sciex_issue_type    i_issue,
   input wire logic [sciex_pkg::CWP_W-1:0]   i_window_upper_bound,
   input wire sciex_pkg::sciex_write_type    o_wr,
   input wire sciex_pkg::sciex_flags_type    o_flags,
   input wire logic [sciex_pkg::CWP_W-1:0]   o_window_pointer,
   input wire logic                          o_trap,
   input wire logic [7:0]                    o_trap_num,
   input wire logic [sciex_pkg::LONG_IMMEDIATE_W-1:0] o_prefix
);
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);
   wire logic        v = i_issue.valid;
   wire logic [15:0] w = i_issue.word;
   AST_PFX_LOAD: assert property (v && w[15:11] == 5'h13
      |=> o_prefix == $past(w[10:0])) else $error("prefix not loaded");
   AST_PFX_CLEAR: assert property (v && w[15:11] != 5'h13
      |=> o_prefix == 11'h0) else $error("prefix not cleared");
   AST_MOVE_SMALL_IMM: assert property (v && w[15:10] == 6'h0d && o_prefix == 11'h0
      |=> o_wr.wr && o_wr.idx == $past(w[4:0]) &&
      o_wr.data == {27'h0, $past(w[9:5])}) else $error("short move");
   AST_MOVE_SMALL_IMM_K: assert property (v && w[15:10] == 6'h0d && o_prefix != 0
      |=> o_wr.data == {16'h0, $past(o_prefix), $past(w[9:5])})
      else $error("prefixed move");
   AST_NEG: assert property (v && w[15:5] == 11'h3e1
      |=> o_wr.data == 32'h0 - $past(i_issue.a_val) && $stable(o_flags))
      else $error("negate");
   AST_WP: assert property (v && w == 16'h7da0
      |=> o_window_pointer == $past(o_window_pointer) + 5'h1)
      else $error("window step");
   AST_TRAP: assert property (v && w == 16'h7da0
      |=> o_trap == $past(o_window_pointer == i_window_upper_bound) &&
      (!o_trap || o_trap_num == 8'h02)) else $error("window trap");
   AST_RLC: assert property (v && w[15:5] == 11'h3e5
      |=> o_flags.c == $past(i_issue.a_val[31]) && o_wr.data ==
      {$past(i_issue.a_val[30:0]), $past(o_flags.c)}) else $error("rotate");
endmodule : sciex_props
bind sciex_exec sciex_props sciex_props_inst (.i_clk_sys(i_clk_sys),
   .i_srst(i_srst), .i_issue(i_issue), .o_wr(o_wr), .o_flags(o_flags),
   .i_window_upper_bound(i_window_upper_bound), .o_trap(o_trap),
   .o_window_pointer(o_window_pointer), .o_trap_num(o_trap_num),
   .o_prefix(o_prefix));

// >>> dv/sciex_regfile.sv
/* Register file model behind the slice.
   Assumes write-back one cycle after issue, so writes are forwarded. */
`timescale 1ns/1ps
module sciex_regfile (
   input  wire logic                       i_clk_sys,
   input  wire logic [4:0]                 i_a_idx,
   input  wire logic [4:0]                 i_b_idx,
   input  wire logic [3:0]                 i_ctl_idx,
   input  wire sciex_pkg::sciex_write_type i_wr,
   output logic [31:0]                     o_a_val,
   output logic [31:0]                     o_b_val,
   output logic [31:0]                     o_r0_val,
   output logic [31:0]                     o_ctl_val
);
   logic [31:0] regs [32];
   logic [31:0] ctl [16];
   always_comb begin
      o_a_val = (i_wr.wr && i_wr.idx == i_a_idx) ? i_wr.data : regs[i_a_idx];
      o_b_val = (i_wr.wr && i_wr.idx == i_b_idx) ? i_wr.data : regs[i_b_idx];
      o_r0_val = (i_wr.wr && i_wr.idx == 5'h0) ? i_wr.data : regs[0];
      o_ctl_val = ctl[i_ctl_idx];
   end
   always @(posedge i_clk_sys) begin
      if (i_wr.wr) begin
         regs[i_wr.idx] <= i_wr.data;
      end
   end
endmodule : sciex_regfile

// >>> dv/tb_sciex_exec.sv
/* Self-checking bench for the execute slice.
   Assumes the register file model sciex_regfile. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   num_errors++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_sciex_exec;
   logic        i_clk_sys = 1'b0;
   logic        i_srst = 1'b1;
   logic        valid = 1'b0;
   logic [15:0] word = 16'h0;
   logic [4:0]  a_idx;
   logic [4:0]  b_idx;
   logic [3:0]  ctl_idx;
   logic [31:0] a_val;
   logic [31:0] b_val;
   logic [31:0] r0_val;
   logic [31:0] ctl_val;
   logic [37:0] wr;
   logic [3:0]  flags;
   logic [4:0]  wp;
   logic        trap;
   logic [7:0]  trap_num;
   logic [10:0] prefix;
   logic        seen_trap;
   logic [4:0]  bound = 5'h01;
   int          num_errors = 0;
   int          cmp_count = 0;
   sciex_regfile sciex_regfile_inst (.i_clk_sys(i_clk_sys), .i_a_idx(a_idx),
      .i_b_idx(b_idx), .i_ctl_idx(ctl_idx), .i_wr(wr), .o_a_val(a_val),
      .o_b_val(b_val), .o_r0_val(r0_val), .o_ctl_val(ctl_val));
   sciex_exec sciex_exec_inst (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
      .i_issue({valid, word, a_val, b_val, r0_val, ctl_val}),
      .i_window_upper_bound(bound), .o_a_idx(a_idx), .o_b_idx(b_idx),
      .o_ctl_idx(ctl_idx), .o_wr(wr), .o_flags(flags), .o_prefix(prefix),
      .o_window_pointer(wp), .o_trap(trap), .o_trap_num(trap_num));
   function automatic logic [31:0] r(input int i);
      return sciex_regfile_inst.regs[i];
   endfunction : r
   task automatic put(input int i, input logic [31:0] d);
      sciex_regfile_inst.regs[i] = d;
   endtask : put
   task automatic run(input logic [15:0] w);
      @(posedge i_clk_sys);
      valid <= 1'b1;
      word <= w;
      @(posedge i_clk_sys);
      valid <= 1'b0;
      @(negedge i_clk_sys);
      seen_trap = trap;
      @(negedge i_clk_sys);
   endtask : run
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   initial begin
      forever #10 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      #40000;
      num_errors++;
      print_verdict();
   end
   initial begin
      sciex_regfile_inst.ctl[0] = 32'h5;
      sciex_regfile_inst.ctl[2] = 32'ha5a5;
      repeat (20) @(posedge i_clk_sys);
      i_srst <= 1'b0;
      run({6'h0d, 5'h07, 5'h03});
      `CHK("move_small_imm", 32'h7, r(3))
      run({5'h13, 11'h009});
      `CHK("prefix", 11'h009, prefix)
      run({6'h0d, 5'h1f, 5'h04});
      `CHK("move_small_imm_k", 32'h13f, r(4))
      `CHK("prefix_clr", 11'h0, prefix)
      run({5'h13, 11'h7ff});
      run({6'h1b, 5'h1f, 5'h03});
      `CHK("move_upper_half_imm", 32'hffff0007, r(3))
      run({6'h10, 5'h04, 5'h03});
      `CHK("or", 32'hffff013f, r(3))
      `CHK("or_flags", 4'h8, flags)
      put(6, 32'h80000001);
      run({11'h3e5, 5'h06});
      `CHK("rlc", 32'h2, r(6))
      `CHK("rlc_flags", 4'h9, flags)
      run({11'h3e1, 5'h06});
      run({11'h3e0, 5'h06});
      `CHK("neg_not", 32'h1, r(6))
      `CHK("flags_kept", 4'h9, flags)
      run({5'h13, 11'h002});
      run({6'h18, 5'h00, 5'h06});
      `CHK("or_k", 32'h41, r(6))
      `CHK("or_k_flags", 4'h1, flags)
      put(0, 32'h80000001);
      put(1, 32'h10);
      run({11'h3f4, 5'h01});
      run({11'h3f4, 5'h01});
      `CHK("multiply_step", 32'h24, r(0))
      put(0, 32'h1234ffff);
      put(2, 32'h3);
      run({11'h3f3, 5'h02});
      `CHK("mul_sgn", 32'hfffd, r(0) & 32'hffff)
      put(0, 32'habcd0100);
      put(2, 32'h200);
      run({11'h3f3, 5'h02});
      `CHK("mul", 32'h20000, r(0))
      run({11'h3f9, 5'h07});
      `CHK("control_read_op", 32'h5, r(7))
      run({5'h13, 11'h002});
      run({11'h3f9, 5'h07});
      `CHK("control_read_op_k", 32'ha5a5, r(7))
      run(16'h7da0);
      `CHK("restore", 6'h01, {seen_trap, wp})
      run(16'h7da0);
      `CHK("trap", 14'h2042, {seen_trap, trap_num, wp})
      print_verdict();
   end
endmodule : tb_sciex_exec

// >>> hdl/sciex_exec.sv
/*
 Execute slice: decodes one issued instruction per valid cycle and produces
 the register write, flag update, window move and trap one cycle later.
 Assumes the fetch stage supplies operands read by the decoded indices.
*/
`timescale 1ns/1ps
// Overview of operation
// - Upper-half move writes prefix:imm into bits 31..16, keeps low half.
// - Small move without prefix loads zero-extended 5-bit immediate.
// - Small move after prefix loads zero-extended prefix:imm 16-bit value.
// - Multiply step shifts register zero left, adds source if bit 31 set.
// - Multiply writes low16 of r0 times low16 of source into r0.
// - Product low half is correct for signed and unsigned operands.
// - Negate writes zero minus the register.
// - Invert complements every bit of the register.
// - Prefix stores its 11-bit immediate into the prefix register.
// - Every non-prefix instruction clears the prefix register.
// - Control read without prefix copies the status register.
// - Control read after prefix copies the control register named by it.
// - Window restore raises the window pointer by one.
// - Restore at the upper bound raises window overflow trap 2.
// - Rotate left through carry: carry into bit 0, bit 31 into carry.
// - Rotate sets carry from old bit 31, keeps other flags.
module sciex_exec (
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_srst,
   input  wire sciex_pkg::sciex_issue_type    i_issue,
   input  wire logic [sciex_pkg::CWP_W-1:0]   i_window_upper_bound,
   output logic [sciex_pkg::GPR_W-1:0]        o_a_idx,
   output logic [sciex_pkg::GPR_W-1:0]        o_b_idx,
   output logic [sciex_pkg::CTL_W-1:0]        o_ctl_idx,
   output sciex_pkg::sciex_write_type         o_wr,
   output sciex_pkg::sciex_flags_type         o_flags,
   output logic [sciex_pkg::CWP_W-1:0]        o_window_pointer,
   output logic                               o_trap,
   output logic [7:0]                         o_trap_num,
   output logic [sciex_pkg::LONG_IMMEDIATE_W-1:0]      o_prefix
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [sciex_pkg::LONG_IMMEDIATE_W-1:0] prefix;
      logic                          prefixed;
      logic [sciex_pkg::CTL_W-1:0]   ctl_idx;
      sciex_pkg::sciex_write_type    wr;
      sciex_pkg::sciex_flags_type    flags;
      logic [sciex_pkg::CWP_W-1:0]   window_pointer;
      logic                          trap;
      logic [7:0]                    trap_num;
   } sciex_state_type;

   sciex_state_type state;
   sciex_state_type next_state;

   // Instruction classes seen by the execute stage
   typedef enum logic [3:0] {
      EX_NONE    = 4'b0000,
      EX_PREFIX  = 4'b0001,
      EX_MOVE_UP = 4'b0010,
      EX_MOVE_SM = 4'b0011,
      EX_OR      = 4'b0100,
      EX_RESTORE = 4'b0101,
      EX_MULTIPLY_STEP   = 4'b0110,
      EX_MUL     = 4'b0111,
      EX_NEG     = 4'b1000,
      EX_NOT     = 4'b1001,
      EX_CONTROL_READ_OP   = 4'b1010,
      EX_RLC     = 4'b1011
   } sciex_class_type;

   sciex_class_type op_class;

   logic [sciex_pkg::INSN_W-1:0]   w;
   logic [sciex_pkg::SHORT_IMMEDIATE_W-1:0]   short_immediate;
   logic [sciex_pkg::DATA_W-1:0]   ext_imm;
   logic [sciex_pkg::DATA_W-1:0]   res;

   // Combined prefix:immediate, zero-extended to a word
   function automatic logic [sciex_pkg::DATA_W-1:0] pfx_imm(
      input logic [sciex_pkg::LONG_IMMEDIATE_W-1:0] k,
      input logic [sciex_pkg::SHORT_IMMEDIATE_W-1:0]  i5);
      pfx_imm = {{sciex_pkg::HALF_W{1'b0}}, k, i5};
   endfunction : pfx_imm

   // Sorts a word into its class; the OR form must match the prefix state
   function automatic sciex_class_type decode_class(
      input logic [sciex_pkg::INSN_W-1:0] word,
      input logic                         prefix_op);
      logic [sciex_pkg::F_RI5_W-1:0] op6;
      logic [sciex_pkg::F_RW_W-1:0]  op11;
      op6  = word[sciex_pkg::F_RI5_LSB +: sciex_pkg::F_RI5_W];
      op11 = word[sciex_pkg::F_RW_LSB +: sciex_pkg::F_RW_W];
      if (word[sciex_pkg::F_PFX_LSB +: sciex_pkg::F_PFX_W] ==
          sciex_pkg::OP_PREFIX) begin
         decode_class = EX_PREFIX;
      end else if (op6 == sciex_pkg::OP_MOVE_UPPER) begin
         decode_class = EX_MOVE_UP;
      end else if (op6 == sciex_pkg::OP_MOVE_SMALL) begin
         decode_class = EX_MOVE_SM;
      end else if ((op6 == sciex_pkg::OP_OR_REG && !prefix_op) ||
                   (op6 == sciex_pkg::OP_OR_IMM && prefix_op)) begin
         decode_class = EX_OR;
      end else if (word == sciex_pkg::OP_RESTORE) begin
         decode_class = EX_RESTORE;
      end else if (op11 == sciex_pkg::OP_MULTIPLY_STEP) begin
         decode_class = EX_MULTIPLY_STEP;
      end else if (op11 == sciex_pkg::OP_MUL) begin
         decode_class = EX_MUL;
      end else if (op11 == sciex_pkg::OP_NEG) begin
         decode_class = EX_NEG;
      end else if (op11 == sciex_pkg::OP_NOT) begin
         decode_class = EX_NOT;
      end else if (op11 == sciex_pkg::OP_CONTROL_READ_OP) begin
         decode_class = EX_CONTROL_READ_OP;
      end else if (op11 == sciex_pkg::OP_RLC) begin
         decode_class = EX_RLC;
      end else begin
         decode_class = EX_NONE;
      end
   endfunction : decode_class

   assign w               = i_issue.word;
   assign short_immediate = w[sciex_pkg::F_B_LSB +: sciex_pkg::SHORT_IMMEDIATE_W];
   assign ext_imm         = pfx_imm(state.prefix, short_immediate);

   // Operand indices to the register file, decoded combinationally; control index is registered
   assign o_a_idx   = w[sciex_pkg::F_A_LSB +: sciex_pkg::GPR_W];
   assign o_b_idx   = w[sciex_pkg::F_B_LSB +: sciex_pkg::GPR_W];
   assign o_ctl_idx = state.ctl_idx;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state          = state;
      next_state.wr.wr    = 1'b0;
      next_state.trap     = 1'b0;
      next_state.wr.idx   = o_a_idx;
      op_class            = decode_class(w, state.prefixed);
      res                 = i_issue.a_val;
      if (i_issue.valid) begin
         next_state.prefix   = '0;
         next_state.prefixed = 1'b0;
         next_state.ctl_idx  = sciex_pkg::CTL_STATUS;
         case (op_class)
            EX_PREFIX: begin
               // Back-to-back prefixes are undefined; the later one wins
               next_state.prefix   = w[sciex_pkg::F_K_LSB +:
                                       sciex_pkg::LONG_IMMEDIATE_W];
               next_state.prefixed = 1'b1;
               next_state.ctl_idx  = w[sciex_pkg::F_K_LSB +:
                                       sciex_pkg::CTL_W];
            end
            EX_MOVE_UP: begin
               res = {ext_imm[sciex_pkg::HALF_W-1:0],
                      i_issue.a_val[sciex_pkg::HALF_W-1:0]};
               next_state.wr.wr = 1'b1;
            end
            EX_MOVE_SM: begin
               res = ext_imm;
               next_state.wr.wr = 1'b1;
            end
            EX_OR: begin
               res = i_issue.a_val |
                     (state.prefixed ? ext_imm : i_issue.b_val);
               next_state.wr.wr   = 1'b1;
               next_state.flags.n = res[sciex_pkg::SIGN_BIT];
               next_state.flags.z = (res == '0);
            end
            EX_RESTORE: begin
               next_state.window_pointer = state.window_pointer + 1'b1;
               if (state.window_pointer == i_window_upper_bound) begin
                  next_state.trap     = 1'b1;
                  next_state.trap_num = sciex_pkg::TRAP_WIN_OVF;
               end
            end
            EX_MULTIPLY_STEP: begin
               res = {i_issue.r0_val[sciex_pkg::SIGN_BIT-1:0], 1'b0} +
                     (i_issue.r0_val[sciex_pkg::SIGN_BIT] ?
                      i_issue.a_val : '0);
               next_state.wr.idx = '0;
               next_state.wr.wr  = 1'b1;
            end
            EX_MUL: begin
               // Low half agrees for signed and unsigned operands
               res = {{sciex_pkg::HALF_W{1'b0}},
                      i_issue.r0_val[sciex_pkg::HALF_W-1:0]} *
                     {{sciex_pkg::HALF_W{1'b0}},
                      i_issue.a_val[sciex_pkg::HALF_W-1:0]};
               next_state.wr.idx = '0;
               next_state.wr.wr  = 1'b1;
            end
            EX_NEG: begin
               res = '0 - i_issue.a_val;
               next_state.wr.wr = 1'b1;
            end
            EX_NOT: begin
               res = ~i_issue.a_val;
               next_state.wr.wr = 1'b1;
            end
            EX_CONTROL_READ_OP: begin
               res = i_issue.ctl_val;
               next_state.wr.wr = 1'b1;
            end
            EX_RLC: begin
               res = {i_issue.a_val[sciex_pkg::SIGN_BIT-1:0],
                      state.flags.c};
               next_state.flags.c =
                  i_issue.a_val[sciex_pkg::SIGN_BIT];
               next_state.wr.wr = 1'b1;
            end
            default: begin
               res = i_issue.a_val;
            end
         endcase
      end
      next_state.wr.data = res;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign o_wr             = state.wr;
   assign o_flags          = state.flags;
   assign o_window_pointer = state.window_pointer;
   assign o_trap           = state.trap;
   assign o_trap_num       = state.trap_num;
   assign o_prefix         = state.prefix;
endmodule : sciex_exec

// >>> hdl/sciex_pkg.sv
/*
 Shared constants and carriers for the instruction execute slice.
 Assumes a 16-bit instruction word and 32-bit general registers.
*/
package sciex_pkg;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned SHORT_IMMEDIATE_W  = 5;
   localparam int unsigned LONG_IMMEDIATE_W = 11;
   localparam int unsigned GPR_W   = 5;
   localparam int unsigned CTL_W   = 4;
   localparam int unsigned CWP_W   = 5;
   // Instruction field positions
   localparam int unsigned F_A_LSB   = 0;
   localparam int unsigned F_B_LSB   = 5;
   localparam int unsigned F_K_LSB   = 0;
   localparam int unsigned F_RW_LSB  = 5;
   localparam int unsigned F_RW_W    = 11;
   localparam int unsigned F_RI5_LSB = 10;
   localparam int unsigned F_RI5_W   = 6;
   localparam int unsigned F_PFX_LSB = 11;
   localparam int unsigned F_PFX_W   = 5;
   localparam int unsigned SIGN_BIT  = 31;
   localparam int unsigned INSN_W    = 16;
   localparam int unsigned HALF_W    = 16;
   // Opcodes, upper bits of the word; restore is matched on the whole word
   localparam logic [5:0]  OP_MOVE_UPPER = 6'h1b;
   localparam logic [5:0]  OP_MOVE_SMALL = 6'h0d;
   localparam logic [5:0]  OP_OR_REG     = 6'h10;
   localparam logic [5:0]  OP_OR_IMM     = 6'h18;
   localparam logic [4:0]  OP_PREFIX     = 5'h13;
   localparam logic [10:0] OP_MULTIPLY_STEP      = 11'h3f4;
   localparam logic [10:0] OP_MUL        = 11'h3f3;
   localparam logic [10:0] OP_NEG        = 11'h3e1;
   localparam logic [10:0] OP_NOT        = 11'h3e0;
   localparam logic [10:0] OP_CONTROL_READ_OP      = 11'h3f9;
   localparam logic [10:0] OP_RLC        = 11'h3e5;
   localparam logic [15:0] OP_RESTORE    = 16'h7da0;
   localparam logic [CTL_W-1:0] CTL_STATUS = 4'h0;
   localparam logic [7:0]  TRAP_WIN_OVF = 8'h02;

   typedef struct packed {
      logic              n;
      logic              v;
      logic              z;
      logic              c;
   } sciex_flags_type;

   typedef struct packed {
      logic              valid;
      logic [15:0]       word;
      logic [DATA_W-1:0] a_val;
      logic [DATA_W-1:0] b_val;
      logic [DATA_W-1:0] r0_val;
      logic [DATA_W-1:0] ctl_val;
   } sciex_issue_type;

   typedef struct packed {
      logic              wr;
      logic [GPR_W-1:0]  idx;
      logic [DATA_W-1:0] data;
   } sciex_write_type;
endpackage : sciex_pkg
